// file: bscu_pkg.sv
package bscu_pkg;
  localparam int BSCU_DW = 8;
  localparam int BSCU_PCW = 16;
  localparam int BSCU_KW = 7;
  localparam int BSCU_IO_AW = 5;
  localparam logic [5:0] BSCU_IO_BIT_MAX = 6'h1F;
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam logic [BSCU_PCW-1:0] BSCU_PC_ONE = 16'h0001;
  localparam logic [BSCU_PCW-1:0] BSCU_PC_TWO = 16'h0002;
  localparam logic [BSCU_PCW-1:0] BSCU_PC_THREE = 16'h0003;
  localparam logic [BSCU_PCW-1:0] BSCU_PC_RESET = 16'h0000;
  localparam logic [BSCU_DW-1:0] BSCU_FLAGS_RESET = 8'h00;

  typedef enum logic [4:0] {
    BSCU_NOP,
    compare_immediate_op,
    skip_reg_bit_clear_op,
    skip_reg_bit_set_op,
    skip_io_bit_clear_op,
    skip_io_bit_set_op,
    branch_status_bit_set_op,
    branch_status_bit_clear_op,
    branch_carry_set_op,
    branch_carry_clear_op,
    branch_unsigned_ge_op,
    branch_unsigned_lt_op,
    branch_signed_ge_op,
    branch_signed_lt_op,
    branch_halfcarry_set_op,
    branch_halfcarry_clear_op,
    branch_tbit_set_op,
    branch_tbit_clear_op
  } bscu_op_t;

  typedef struct packed {
    bscu_op_t op;
    logic [BSCU_DW-1:0] reg_val;
    logic [BSCU_DW-1:0] imm;
    logic [BSCU_IO_AW:0] io_addr;
    logic [BSCU_DW-1:0] io_val;
    logic [2:0] bit_sel;
    logic [BSCU_KW-1:0] k;
    logic next_two_word;
  } bscu_instr_t;

  typedef struct packed {
    logic [BSCU_PCW-1:0] pc;
    logic [BSCU_DW-1:0] flags;
    logic busy;
    logic done;
    logic taken;
    logic io_bad;
  } bscu_state_t;
endpackage

// file: bscu_core.sv
// Operation
// - compare immediate sets ZNVSCH, one cycle
// - register bit skip, flags untouched
// - io bit skip, pc plus 2 or 3
// - status bit s branch, pc+k+1
// - carry branches test C
// - unsigned branches use carry flag
// - signed branches use N xor V
// - half-carry branches test H
// - T flag branches test T
// - io bit skip only addresses 0 to 1F
`timescale 1ns/100ps
module bscu_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire bscu_pkg::bscu_instr_t instr,
  output bscu_pkg::bscu_state_t state
);
  import bscu_pkg::*;

  typedef enum logic [1:0] {BSCU_IDLE, BSCU_WAIT1, BSCU_WAIT2} bscu_fsm_t;

  bscu_fsm_t fsm_reg, fsm_next;
  bscu_state_t st_reg, st_next;

  function automatic logic pick_bit(input logic [BSCU_DW-1:0] v,
                                    input logic [2:0] b);
    pick_bit = v[b];
  endfunction

  logic [BSCU_DW:0] diff;
  logic cond, is_skip, is_branch, io_ok;
  logic [BSCU_DW-1:0] f;
  logic [BSCU_PCW-1:0] k_ext;

  always_comb begin
    fsm_next = fsm_reg;
    st_next = st_reg;
    st_next.done = 1'b0;
    f = st_reg.flags;
    diff = {1'b0, instr.reg_val} - {1'b0, instr.imm};
    k_ext = BSCU_PCW'(signed'(instr.k));
    io_ok = (instr.io_addr <= BSCU_IO_BIT_MAX);
    is_skip = 1'b0;
    is_branch = 1'b0;
    cond = 1'b0;
    case (instr.op)
      skip_reg_bit_clear_op: begin
        is_skip = 1'b1;
        cond = !pick_bit(instr.reg_val, instr.bit_sel);
      end
      skip_reg_bit_set_op: begin
        is_skip = 1'b1;
        cond = pick_bit(instr.reg_val, instr.bit_sel);
      end
      skip_io_bit_clear_op: begin
        is_skip = 1'b1;
        cond = io_ok && !pick_bit(instr.io_val, instr.bit_sel);
      end
      skip_io_bit_set_op: begin
        is_skip = 1'b1;
        cond = io_ok && pick_bit(instr.io_val, instr.bit_sel);
      end
      branch_status_bit_set_op: begin
        is_branch = 1'b1;
        cond = pick_bit(f, instr.bit_sel);
      end
      branch_status_bit_clear_op: begin
        is_branch = 1'b1;
        cond = !pick_bit(f, instr.bit_sel);
      end
      branch_carry_set_op: begin
        is_branch = 1'b1;
        cond = f[FLG_C];
      end
      branch_carry_clear_op: begin
        is_branch = 1'b1;
        cond = !f[FLG_C];
      end
      branch_unsigned_ge_op: begin
        is_branch = 1'b1;
        cond = !f[FLG_C];
      end
      branch_unsigned_lt_op: begin
        is_branch = 1'b1;
        cond = f[FLG_C];
      end
      branch_signed_ge_op: begin
        is_branch = 1'b1;
        cond = !(f[FLG_N] ^ f[FLG_V]);
      end
      branch_signed_lt_op: begin
        is_branch = 1'b1;
        cond = f[FLG_N] ^ f[FLG_V];
      end
      branch_halfcarry_set_op: begin
        is_branch = 1'b1;
        cond = f[FLG_H];
      end
      branch_halfcarry_clear_op: begin
        is_branch = 1'b1;
        cond = !f[FLG_H];
      end
      branch_tbit_set_op: begin
        is_branch = 1'b1;
        cond = f[FLG_T];
      end
      branch_tbit_clear_op: begin
        is_branch = 1'b1;
        cond = !f[FLG_T];
      end
      default: begin
        cond = 1'b0;
      end
    endcase
    case (fsm_reg)
      BSCU_IDLE: begin
        if (instr_valid) begin
          st_next.taken = cond;
          st_next.io_bad = 1'b0;
          if (instr.op == compare_immediate_op) begin
            // result dropped, only flags kept
            st_next.flags[FLG_C] = diff[BSCU_DW];
            st_next.flags[FLG_Z] = (diff[BSCU_DW-1:0] == '0);
            st_next.flags[FLG_N] = diff[BSCU_DW-1];
            st_next.flags[FLG_V] = (instr.reg_val[BSCU_DW-1] ^
                                    instr.imm[BSCU_DW-1]) &
                                   (instr.reg_val[BSCU_DW-1] ^
                                    diff[BSCU_DW-1]);
            st_next.flags[FLG_S] = diff[BSCU_DW-1] ^ st_next.flags[FLG_V];
            st_next.flags[FLG_H] = (instr.reg_val[3:0] < instr.imm[3:0]);
            st_next.pc = st_reg.pc + BSCU_PC_ONE;
            st_next.done = 1'b1;
          end else if (is_skip) begin
            // unmapped io address never skips, flagged for the core
            if ((instr.op == skip_io_bit_clear_op ||
                 instr.op == skip_io_bit_set_op) && !io_ok) begin
              st_next.io_bad = 1'b1;
            end
            if (cond) begin
              st_next.pc = st_reg.pc + (instr.next_two_word ?
                           BSCU_PC_THREE : BSCU_PC_TWO);
              st_next.busy = 1'b1;
              fsm_next = instr.next_two_word ? BSCU_WAIT2 :
                         BSCU_WAIT1;
            end else begin
              st_next.pc = st_reg.pc + BSCU_PC_ONE;
              st_next.done = 1'b1;
            end
          end else if (is_branch) begin
            if (cond) begin
              st_next.pc = st_reg.pc + k_ext + BSCU_PC_ONE;
              st_next.busy = 1'b1;
              fsm_next = BSCU_WAIT1;
            end else begin
              st_next.pc = st_reg.pc + BSCU_PC_ONE;
              st_next.done = 1'b1;
            end
          end else begin
            st_next.pc = st_reg.pc + BSCU_PC_ONE;
            st_next.done = 1'b1;
          end
        end
      end
      BSCU_WAIT2: begin
        fsm_next = BSCU_WAIT1;
      end
      BSCU_WAIT1: begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
        fsm_next = BSCU_IDLE;
      end
      default: begin
        fsm_next = BSCU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fsm_reg <= BSCU_IDLE;
      st_reg <= '{pc: BSCU_PC_RESET, flags: BSCU_FLAGS_RESET,
                 default: 1'b0};
    end else begin
      fsm_reg <= fsm_next;
      st_reg <= st_next;
    end
  end

  assign state = st_reg;

  // busy stretch equals the extra cycles of a taken skip or branch
  sequence s_one_extra;
    state.busy ##1 (!state.busy && state.done);
  endsequence
  sequence s_two_extra;
    state.busy [*2] ##1 (!state.busy && state.done);
  endsequence

  AST_CPI_ONE_CYCLE: assert property (
    @(posedge clk) disable iff (rst)
    (fsm_reg == BSCU_IDLE && instr_valid &&
     instr.op == compare_immediate_op)
    |=> (state.done && !state.busy &&
         state.pc == $past(state.pc) + BSCU_PC_ONE))
    else $error("compare not done in one cycle");
  AST_CPI_ZERO: assert property (
    @(posedge clk) disable iff (rst)
    (fsm_reg == BSCU_IDLE && instr_valid &&
     instr.op == compare_immediate_op && instr.reg_val == instr.imm)
    |=> (state.flags[FLG_Z] && !state.flags[FLG_C]))
    else $error("compare equal flags wrong");
  AST_SKIP_FLAGS: assert property (
    @(posedge clk) disable iff (rst)
    (fsm_reg == BSCU_IDLE && instr_valid && is_skip)
    |=> $stable(state.flags))
    else $error("skip changed flags");
  AST_SKIP_PC: assert property (
    @(posedge clk) disable iff (rst)
    (fsm_reg == BSCU_IDLE && instr_valid && is_skip && cond)
    |=> (state.pc == $past(state.pc) +
         ($past(instr.next_two_word) ? BSCU_PC_THREE : BSCU_PC_TWO)))
    else $error("skip pc wrong");
  // target rebuilt from the raw offset, not from k_ext
  AST_BRANCH_PC: assert property (
    @(posedge clk) disable iff (rst)
    (fsm_reg == BSCU_IDLE && instr_valid && is_branch && cond)
    |=> (state.pc == $past(state.pc) + BSCU_PC_ONE +
         {{(BSCU_PCW-BSCU_KW){$past(instr.k[BSCU_KW-1])}},
          $past(instr.k)}))
    else $error("branch target wrong");
  AST_BRANCH_FLAGS: assert property (
    @(posedge clk) disable iff (rst)
    (fsm_reg == BSCU_IDLE && instr_valid && is_branch)
    |=> $stable(state.flags))
    else $error("branch changed flags");
  AST_SIGNED_LT: assert property (
    @(posedge clk) disable iff (rst)
    (fsm_reg == BSCU_IDLE && instr_valid &&
     instr.op == branch_signed_lt_op)
    |=> (state.taken == (state.flags[FLG_N] ^ state.flags[FLG_V])))
    else $error("signed less branch decision wrong");
  AST_IO_RANGE: assert property (
    @(posedge clk) disable iff (rst)
    (fsm_reg == BSCU_IDLE && instr_valid &&
     (instr.op == skip_io_bit_set_op || instr.op == skip_io_bit_clear_op)
     && instr.io_addr > BSCU_IO_BIT_MAX)
    |=> (!state.taken && state.io_bad))
    else $error("out of range io skip acted");
  AST_SKIP1_TIME: assert property (
    @(posedge clk) disable iff (rst)
    (fsm_reg == BSCU_IDLE && instr_valid && is_skip && cond &&
     !instr.next_two_word)
    |=> s_one_extra)
    else $error("one word skip timing wrong");
  AST_SKIP2_TIME: assert property (
    @(posedge clk) disable iff (rst)
    (fsm_reg == BSCU_IDLE && instr_valid && is_skip && cond &&
     instr.next_two_word)
    |=> s_two_extra)
    else $error("two word skip timing wrong");
  AST_BRANCH_TIME: assert property (
    @(posedge clk) disable iff (rst)
    (fsm_reg == BSCU_IDLE && instr_valid && is_branch && cond)
    |=> s_one_extra)
    else $error("taken branch timing wrong");
endmodule

// file: tb_branch_skip_condition_unit.sv
`timescale 1ns/100ps
module tb_branch_skip_condition_unit;
  import bscu_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  bscu_instr_t instr = '0;
  bscu_state_t state;
  int failures = 0;
  int tests_run = 0;
  logic [15:0] pc_m = 16'h0000;
  logic [7:0] fl_m = 8'h00;

  always #10 clk = ~clk;

  bscu_core dut (
    .clk(clk),
    .rst(rst),
    .instr_valid(instr_valid),
    .instr(instr),
    .state(state)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one instruction, then count edges until done; bounded wait
  task automatic exec(bscu_op_t op, logic [7:0] rv, logic [7:0] im,
      logic [5:0] ia, logic [2:0] bs, logic [6:0] k, logic tw,
      logic [15:0] dpc, int ncyc);
    int n;
    int nb;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= '{op, rv, im, ia, rv, bs, k, tw};
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    n = 1;
    nb = (state.busy !== 1'b0) ? 1 : 0;
    while (state.done !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
      if (state.busy !== 1'b0) nb++;
    end
    if (n >= 8) begin
      failures++;
      wrap_up();
    end
    pc_m = pc_m + dpc;
    chk("pc", state.pc, pc_m);
    chk("cycles", 16'(n), 16'(ncyc));
    chk("busy", 16'(nb), 16'(ncyc - 1));
  endtask

  function automatic logic [7:0] cpi_f(logic [7:0] a, logic [7:0] b);
    logic [7:0] r;
    logic v;
    r = a - b;
    v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    cpi_f = {fl_m[7:6], (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]),
             r[7] ^ v, v, r[7], r == 8'h00, a < b};
  endfunction

  function automatic logic cond(bscu_op_t op, logic [7:0] f, int s);
    case (op)
      branch_status_bit_set_op: cond = f[s];
      branch_status_bit_clear_op: cond = !f[s];
      branch_carry_set_op, branch_unsigned_lt_op: cond = f[FLG_C];
      branch_carry_clear_op, branch_unsigned_ge_op: cond = !f[FLG_C];
      branch_signed_lt_op: cond = f[FLG_N] ^ f[FLG_V];
      branch_signed_ge_op: cond = !(f[FLG_N] ^ f[FLG_V]);
      branch_halfcarry_set_op: cond = f[FLG_H];
      branch_halfcarry_clear_op: cond = !f[FLG_H];
      branch_tbit_set_op: cond = f[FLG_T];
      default: cond = !f[FLG_T];
    endcase
  endfunction

  task automatic t_cpi(logic [7:0] a, logic [7:0] b);
    fl_m = cpi_f(a, b);
    exec(compare_immediate_op, a, b, 6'h00, 3'h0, 7'h00, 1'b0, 16'h0001, 1);
    chk("flags", 16'(state.flags), 16'(fl_m));
  endtask

  // every branch kind, every status bit, extreme offsets both ways
  task automatic t_branches(logic [7:0] a, logic [7:0] b);
    logic c;
    logic [6:0] k;
    t_cpi(a, b);
    for (int i = 6; i <= 17; i++) begin
      for (int s = 0; s < 8; s++) begin
        k = s[0] ? 7'h40 : 7'h3F;
        c = cond(bscu_op_t'(i), fl_m, s);
        exec(bscu_op_t'(i), 8'h00, 8'h00, 6'h00, 3'(s), k, 1'b0,
             c ? {{9{k[6]}}, k} + 16'h0001 : 16'h0001, c ? 2 : 1);
        chk("taken", 16'(state.taken), 16'(c));
        chk("flags", 16'(state.flags), 16'(fl_m));
      end
    end
    $display("test branches %h %h done", a, b);
  endtask

  // skip over one- and two-word instructions, io window edge
  task automatic t_skips(bscu_op_t op, logic [5:0] ia);
    logic sk;
    int w;
    logic [7:0] pat;
    for (int b = 0; b < 8; b++) begin
      for (int tw = 0; tw < 2; tw++) begin
        pat = 8'hA5 >> b;
        sk = (op == skip_reg_bit_set_op || op == skip_io_bit_set_op) ?
             pat[0] : !pat[0];
        sk = sk & (ia <= 6'h1F);
        w = sk ? 2 + tw : 1;
        exec(op, 8'hA5, 8'h00, ia, 3'(b), 7'h00, tw[0], 16'(w), w);
        chk("io_bad", 16'(state.io_bad), 16'(ia > 6'h1F));
        chk("flags", 16'(state.flags), 16'(fl_m));
      end
    end
    $display("test skips op %0d addr %h done", op, ia);
  endtask

  // offers while stalled must be dropped without side effects
  task automatic t_stall_offer();
    t_cpi(8'h10, 8'h20);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= '{branch_carry_set_op, 8'h00, 8'h00, 6'h00, 8'h00, 3'h0,
               7'h00, 1'b0};
    @(posedge clk);
    instr <= '{compare_immediate_op, 8'h05, 8'h05, 6'h00, 8'h05, 3'h0,
               7'h00, 1'b0};
    @(posedge clk);
    instr_valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    pc_m = pc_m + 16'h0001;
    chk("pc", state.pc, pc_m);
    chk("flags", 16'(state.flags), 16'(fl_m));
    $display("test stall offer done");
  endtask

  task automatic t_reset();
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    pc_m = 16'h0000;
    fl_m = 8'h00;
    chk("pc", state.pc, pc_m);
    chk("flags", 16'(state.flags), 16'(fl_m));
    chk("status", 16'({state.busy, state.done, state.taken,
                      state.io_bad}), 16'h0000);
    $display("test reset done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_cpi(8'h05, 8'h05);
    t_cpi(8'h80, 8'h01);
    t_cpi(8'h10, 8'h01);
    t_cpi(8'h00, 8'hFF);
    $display("test compare done");
    t_branches(8'h10, 8'h20);
    t_branches(8'h10, 8'h01);
    t_branches(8'h80, 8'h01);
    t_skips(skip_reg_bit_clear_op, 6'h00);
    t_skips(skip_reg_bit_set_op, 6'h00);
    t_skips(skip_io_bit_clear_op, 6'h1F);
    t_skips(skip_io_bit_set_op, 6'h1F);
    t_skips(skip_io_bit_set_op, 6'h20);
    t_skips(skip_io_bit_clear_op, 6'h20);
    t_stall_offer();
    t_reset();
    t_cpi(8'h7F, 8'h80);
    wrap_up();
  end
endmodule
